//--- ugev_pkg.sv
// constants shared by the global event and address logic of the usb block
// assumes an 8-bit special function register bus and a 25 MHz system clock
// Operation
// - event flag/enable bits 7,6,2,1 read zero
// - wake flag set by bus activity in suspend
// - wake flag interrupts only when enabled
// - end-of-reset flag set, held until cleared
// - end-of-reset interrupts only when enabled
// - end-of-reset enable comes up set
// - start-of-frame flag set on sof token
// - start-of-frame interrupts only when enabled
// - suspend flag after 3 ms idle J
// - suspend flag interrupts only when enabled
// - filter enable bit turns address filtering on
// - address field zero after reset, reads 80h
// - endpoint index low four bits, upper zero
// - bus reset is se0 for 32 bit times
// - clock gate stops usb clock, resume works
package ugev_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS   = 8'hbd; // event flags
  localparam logic [7:0] OFS_ENABLES = 8'hbe; // event enables
  localparam logic [7:0] OFS_ADDR    = 8'hc6; // function address
  localparam logic [7:0] OFS_EPSEL   = 8'hc7; // endpoint selector
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_WAKE    = 5; // wake flag / enable
  localparam int BIT_RSTEND  = 4; // end-of-reset flag / enable
  localparam int BIT_SOF     = 3; // start-of-frame flag / enable
  localparam int BIT_SUSP    = 0; // suspend flag / enable
  localparam int BIT_FILTER  = 7; // address filter enable
  localparam logic [7:0] EVT_MASK = 8'h39; // implemented event bits
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h10; // end-of-reset enabled
  localparam logic [7:0] RST_ADDR    = 8'h80; // filter on, address 0
  localparam logic [3:0] RST_EPSEL   = 4'h0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int FS_BIT_HZ     = 12_000_000; // full-speed bit rate
  localparam int RST_SE0_BITS  = 32;         // least se0 for bus reset
  // least time, so round up
  localparam int RST_SE0_CYC   =
    (RST_SE0_BITS * CLK_HZ + FS_BIT_HZ - 1) / FS_BIT_HZ;
  localparam int SUSP_IDLE_MS  = 3;          // idle time before suspend
  localparam int SUSP_IDLE_CYC = SUSP_IDLE_MS * (CLK_HZ / 1000);
  // line states
  typedef enum logic {ST_RUN, ST_SUSP} ugev_st_t;
endpackage : ugev_pkg

//--- ugev_top.sv
// usb global events, interrupt request, function address, endpoint select
// assumes the sie gives synchronous line levels and a sof-token pulse
`timescale 1ns/100ps
module ugev_top #(
  parameter int SUSP_CYC = ugev_pkg::SUSP_IDLE_CYC // idle cycles to suspend
) (
  input  wire logic       clk_sys,            // system clock
  input  wire logic       nrst,               // async reset, low
  input  wire logic [7:0] sfr_addr,           // register address
  input  wire logic       sfr_wr,             // write strobe
  input  wire logic       sfr_rd,             // read strobe
  input  wire logic [7:0] sfr_wdata,          // write data
  output logic      [7:0] sfr_rdata_q,        // read data, next cycle
  input  wire logic       line_dp,            // received d+ level
  input  wire logic       line_dm,            // received d- level
  input  wire logic       sof_pid_seen,       // sof token pulse
  input  wire logic       upstream_resume,    // own resume in progress
  input  wire logic       suspend_clock_gate, // gate 48 MHz clock
  output logic            usb_clk_en_q,       // 48 MHz clock enable
  output logic            usb_irq_q,          // usb interrupt request
  output logic      [6:0] function_address_q, // address to match
  output logic            address_filter_enable_q, // filtering on
  output logic      [3:0] endpoint_index_q,   // selected endpoint
  output logic            bus_reset_q         // bus reset in progress
);
  import ugev_pkg::*;

  // ---------------------------------------------------------------
  // line decode and state
  // ---------------------------------------------------------------
  localparam logic [6:0]  SE0_LIM  = 7'(RST_SE0_CYC - 1);
  localparam logic [16:0] SUSP_LIM = 17'(SUSP_CYC - 1);

  logic        line_j;      // idle j state
  logic        line_se0;    // single-ended zero
  logic [6:0]  se0_cnt_q;   // se0 length
  logic [16:0] idle_cnt_q;  // idle j length
  ugev_st_t    st_q;        // running or suspended
  logic        rst_end;     // se0 just ended after a bus reset
  logic        susp_evt;    // idle long enough
  logic        wake_evt;    // bus activity while suspended
  logic [7:0]  flags_q;     // event flags
  logic [7:0]  en_q;        // event enables
  logic [7:0]  set_v;       // hardware sets this cycle
  logic [7:0]  clr_v;       // software clears this cycle
  logic        wr_flags;
  logic        wr_en;
  logic        wr_addr;
  logic        wr_ep;

  assign line_j   = line_dp & ~line_dm;
  assign line_se0 = ~line_dp & ~line_dm;
  assign rst_end  = bus_reset_q & ~line_se0;
  assign susp_evt = (st_q == ST_RUN) && line_j &&
                    (idle_cnt_q == SUSP_LIM);
  // the device's own resume is not a wake source
  assign wake_evt = (st_q == ST_SUSP) && !line_j &&
                    !upstream_resume;

  assign wr_flags = sfr_wr && (sfr_addr == OFS_FLAGS);
  assign wr_en    = sfr_wr && (sfr_addr == OFS_ENABLES);
  assign wr_addr  = sfr_wr && (sfr_addr == OFS_ADDR);
  assign wr_ep    = sfr_wr && (sfr_addr == OFS_EPSEL);

  // se0 length counter, saturates at the reset threshold
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      se0_cnt_q <= 7'h00;
    end else if (!line_se0) begin
      se0_cnt_q <= 7'h00;
    end else if (se0_cnt_q != SE0_LIM) begin
      se0_cnt_q <= se0_cnt_q + 7'h01;
    end
  end

  // bus reset held from threshold until se0 ends
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_reset_q <= 1'b0;
    end else if (line_se0 && se0_cnt_q == SE0_LIM) begin
      bus_reset_q <= 1'b1;
    end else if (rst_end) begin
      bus_reset_q <= 1'b0;
    end
  end

  // idle j counter; stops while suspended so one suspend is flagged
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idle_cnt_q <= 17'h00000;
    end else if (!line_j || st_q == ST_SUSP || susp_evt) begin
      idle_cnt_q <= 17'h00000;
    end else begin
      idle_cnt_q <= idle_cnt_q + 17'h00001;
    end
  end

  // suspend state, left on any non-idle line level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_RUN;
    end else begin
      case (st_q)
        ST_RUN:  if (susp_evt) st_q <= ST_SUSP;
        ST_SUSP: if (!line_j) st_q <= ST_RUN;
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // event flags and enables
  // ---------------------------------------------------------------
  always_comb begin
    set_v             = 8'h00;
    set_v[BIT_WAKE]   = wake_evt;
    set_v[BIT_RSTEND] = rst_end;
    set_v[BIT_SOF]    = sof_pid_seen;
    set_v[BIT_SUSP]   = susp_evt;
    // writing zero clears, writing one leaves the flag alone
    clr_v = wr_flags ? ~sfr_wdata : 8'h00;
  end

  // set wins over a clear in the same cycle; reserved bits stay zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_q <= RST_FLAGS;
    end else begin
      flags_q <= ((flags_q & ~clr_v) | set_v) & EVT_MASK;
    end
  end

  // enables; reserved bits are dropped on write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_q <= RST_ENABLES;
    end else if (wr_en) begin
      en_q <= sfr_wdata & EVT_MASK;
    end
  end

  // interrupt request follows the enabled flags one cycle later
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      usb_irq_q <= 1'b0;
    end else begin
      usb_irq_q <= |(flags_q & en_q);
    end
  end

  // ---------------------------------------------------------------
  // address, endpoint select, clock gate
  // ---------------------------------------------------------------
  // bus reset forces address 0 but keeps the filter bit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      function_address_q      <= RST_ADDR[6:0];
      address_filter_enable_q <= RST_ADDR[BIT_FILTER];
    end else if (bus_reset_q) begin
      function_address_q <= 7'h00;
    end else if (wr_addr) begin
      function_address_q      <= sfr_wdata[6:0];
      address_filter_enable_q <= sfr_wdata[BIT_FILTER];
    end
  end

  // only the low nibble is stored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      endpoint_index_q <= RST_EPSEL;
    end else if (wr_ep) begin
      endpoint_index_q <= sfr_wdata[3:0];
    end
  end

  // resume detection runs on clk_sys, so gating is safe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      usb_clk_en_q <= 1'b1;
    end else begin
      usb_clk_en_q <= ~suspend_clock_gate;
    end
  end

  // ---------------------------------------------------------------
  // read port, one cycle latency, unmapped reads zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        OFS_FLAGS:   sfr_rdata_q <= flags_q;
        OFS_ENABLES: sfr_rdata_q <= en_q;
        OFS_ADDR:    sfr_rdata_q <= {address_filter_enable_q,
                                     function_address_q};
        OFS_EPSEL:   sfr_rdata_q <= {4'h0, endpoint_index_q};
        default:     sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_rsvd_bits_zero: assert property (
    flags_q[7:6] == 2'b00 && flags_q[2:1] == 2'b00 &&
    en_q[7:6] == 2'b00 && en_q[2:1] == 2'b00)
    else $error("reserved event bit set");
  a_wake_flag_set: assert property (
    st_q == ST_SUSP && !line_j && !upstream_resume |=> flags_q[BIT_WAKE])
    else $error("wake flag not set");
  a_wake_irq_gate: assert property (
    flags_q[BIT_WAKE] && en_q[BIT_WAKE] |=> usb_irq_q)
    else $error("wake interrupt missing");
  a_rstend_flag_set: assert property (
    bus_reset_q && !line_se0 |=> flags_q[BIT_RSTEND] && !bus_reset_q)
    else $error("end-of-reset flag not set");
  a_rstend_irq_gate: assert property (
    flags_q[BIT_RSTEND] && en_q[BIT_RSTEND] |=> usb_irq_q)
    else $error("end-of-reset interrupt missing");
  a_sof_flag_set: assert property (
    sof_pid_seen |=> flags_q[BIT_SOF])
    else $error("sof flag not set");
  a_sof_irq_gate: assert property (
    flags_q[BIT_SOF] && en_q[BIT_SOF] |=> usb_irq_q)
    else $error("sof interrupt missing");
  a_susp_flag_set: assert property (
    $rose(st_q == ST_SUSP) |-> flags_q[BIT_SUSP] &&
    $past(idle_cnt_q) == SUSP_LIM)
    else $error("suspend entered without flag");
  a_susp_irq_gate: assert property (
    flags_q[BIT_SUSP] && en_q[BIT_SUSP] |=> usb_irq_q)
    else $error("suspend interrupt missing");
  a_addr_bus_rst: assert property (
    bus_reset_q |=> function_address_q == 7'h00)
    else $error("address not cleared by bus reset");
  a_epsel_upper_zero: assert property (
    sfr_rd && sfr_addr == OFS_EPSEL |=> sfr_rdata_q[7:4] == 4'h0)
    else $error("endpoint select upper bits not zero");
  a_se0_threshold: assert property (
    $rose(bus_reset_q) |-> $past(se0_cnt_q) == SE0_LIM &&
    $past(line_se0))
    else $error("bus reset without full se0");
  a_irq_quiet: assert property (
    (flags_q & en_q) == 8'h00 |=> !usb_irq_q)
    else $error("interrupt without enabled flag");
  a_set_beats_clr: assert property (
    sof_pid_seen && wr_flags && !sfr_wdata[BIT_SOF] |=> flags_q[BIT_SOF])
    else $error("clear beat hardware set");

  c_bus_reset_end: cover property (rst_end);
  c_suspend_wake: cover property (st_q == ST_SUSP ##[1:20] wake_evt);
  c_sof_irq: cover property (sof_pid_seen && en_q[BIT_SOF] ##2 usb_irq_q);
  c_set_clr_clash: cover property (sof_pid_seen && wr_flags);
endmodule : ugev_top

//--- ugev_host_model.sv
// usb host stand-in: line levels and sof token pulses for the event block
// assumes the bench picks the line state just after a clock edge
`timescale 1ns/100ps
module ugev_host_model (
  input  wire logic [1:0] mode,        // 0 idle j, 1 k, 2 se0
  input  wire logic       sof_req,     // one-cycle token request
  output logic            line_dp,     // d+ level
  output logic            line_dm,     // d- level
  output logic            sof_pid_seen // sof token decoded
);
  // ---------------------------------------------------------------
  // line drive
  // ---------------------------------------------------------------
  // host always drives the pair, so no floating level to model
  assign line_dp = (mode == 2'h0); // idle j state
  // k is non-idle; se0 (both low) held long is a bus reset
  assign line_dm = (mode == 2'h1);
  assign sof_pid_seen = sof_req; // one pulse per token
endmodule : ugev_host_model

//--- ugev_top_tb.sv
// self-checking bench for the usb global event and address block
// assumes the host stand-in model and a 25 MHz system clock
`timescale 1ns/100ps
module ugev_top_tb;
  import ugev_pkg::*;
  localparam int SUSP = 50; // short idle span keeps the run brief
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sof_req = 1'b0;
  logic [1:0] mode = 2'h1; // busy k until a test says otherwise
  logic       upstream_resume = 1'b0;
  logic       suspend_clock_gate = 1'b0;
  logic [7:0] sfr_rdata_q;
  logic       line_dp, line_dm, sof_pid_seen;
  logic       usb_clk_en_q, usb_irq_q, address_filter_enable_q;
  logic [6:0] function_address_q;
  logic [3:0] endpoint_index_q;
  logic       bus_reset_q;
  int         error_cnt = 0;
  int         samples_checked = 0;
  // ---------------------------------------------------------------
  // clock, host model and design
  // ---------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;
  ugev_host_model u_host (.mode(mode), .sof_req(sof_req),
    .line_dp(line_dp), .line_dm(line_dm), .sof_pid_seen(sof_pid_seen));
  ugev_top #(.SUSP_CYC(SUSP)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .line_dp(line_dp), .line_dm(line_dm), .sof_pid_seen(sof_pid_seen),
    .upstream_resume(upstream_resume),
    .suspend_clock_gate(suspend_clock_gate),
    .usb_clk_en_q(usb_clk_en_q), .usb_irq_q(usb_irq_q),
    .function_address_q(function_address_q),
    .address_filter_enable_q(address_filter_enable_q),
    .endpoint_index_q(endpoint_index_q), .bus_reset_q(bus_reset_q));
  // ---------------------------------------------------------------
  // helper tasks
  // ---------------------------------------------------------------
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // one write strobe, taken at the second edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask : wr
  // read data is registered, so look half a cycle after the taking edge
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(negedge clk_sys);
    chk(sfr_rdata_q, e);
  endtask : rd
  // lets a registered output one cycle behind a write land
  task settle;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle
  task bus_state(input logic [1:0] m, input int n);
    @(posedge clk_sys);
    mode <= m;
    repeat (n) @(posedge clk_sys);
  endtask : bus_state
  // reset is driven on a rising edge like every other input
  task do_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask : do_reset
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------
  // watchdog: the tests need well under a thousand cycles
  // ---------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    end_sim;
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    do_reset;
    rd(OFS_FLAGS, 8'h00);
    rd(OFS_ENABLES, 8'h10);
    rd(OFS_ADDR, 8'h80);
    rd(OFS_EPSEL, 8'h00);
    rd(8'h55, 8'h00);
    wr(OFS_ENABLES, 8'hff);
    rd(OFS_ENABLES, 8'h39);
    wr(OFS_EPSEL, 8'hff);
    rd(OFS_EPSEL, 8'h0f);
    chk(8'(endpoint_index_q), 8'h0f);
    wr(OFS_FLAGS, 8'hff);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_ENABLES, 8'h10);
    $display("test registers done");
    // short se0 is no reset, long se0 resets the address
    wr(OFS_ADDR, 8'h85);
    bus_state(2'h2, 64);
    mode <= 2'h1;
    @(negedge clk_sys);
    chk(8'(bus_reset_q), 8'h00);
    rd(OFS_FLAGS, 8'h00);
    bus_state(2'h2, 72);
    @(negedge clk_sys);
    chk(8'(bus_reset_q), 8'h01);
    bus_state(2'h1, 3);
    @(negedge clk_sys);
    chk(8'(usb_irq_q), 8'h01);
    chk(8'(function_address_q), 8'h00);
    rd(OFS_ADDR, 8'h80);
    wr(OFS_ENABLES, 8'h00);
    settle;
    chk(8'(usb_irq_q), 8'h00);
    rd(OFS_FLAGS, 8'h10);
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_ADDR, 8'h05);
    settle;
    chk(8'(address_filter_enable_q), 8'h00);
    chk(8'(function_address_q), 8'h05);
    $display("test bus reset done");
    // start of frame, then a clear racing a new token
    wr(OFS_ENABLES, 8'h08);
    @(posedge clk_sys);
    sof_req <= 1'b1;
    @(posedge clk_sys);
    sof_req <= 1'b0;
    settle;
    chk(8'(usb_irq_q), 8'h01);
    rd(OFS_FLAGS, 8'h08);
    wr(OFS_ENABLES, 8'h00);
    settle;
    chk(8'(usb_irq_q), 8'h00);
    @(posedge clk_sys);
    sfr_addr  <= OFS_FLAGS;
    sfr_wdata <= 8'h00;
    sfr_wr    <= 1'b1;
    sof_req   <= 1'b1;
    @(posedge clk_sys);
    sfr_wr  <= 1'b0;
    sof_req <= 1'b0;
    rd(OFS_FLAGS, 8'h08);
    wr(OFS_FLAGS, 8'h00);
    $display("test frame start done");
    // suspend after idle j, resume from own drive and from the host
    wr(OFS_ENABLES, 8'h01);
    bus_state(2'h0, 45);
    @(negedge clk_sys);
    chk(8'(usb_irq_q), 8'h00);
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(8'(usb_irq_q), 8'h01);
    rd(OFS_FLAGS, 8'h01);
    @(posedge clk_sys);
    upstream_resume <= 1'b1;
    bus_state(2'h1, 4);
    rd(OFS_FLAGS, 8'h01);
    wr(OFS_FLAGS, 8'h00);
    upstream_resume <= 1'b0;
    bus_state(2'h0, 55);
    suspend_clock_gate <= 1'b1;
    settle;
    chk(8'(usb_clk_en_q), 8'h00);
    bus_state(2'h1, 3);
    rd(OFS_FLAGS, 8'h21);
    wr(OFS_ENABLES, 8'h20);
    settle;
    chk(8'(usb_irq_q), 8'h01);
    wr(OFS_ENABLES, 8'h00);
    settle;
    chk(8'(usb_irq_q), 8'h00);
    @(posedge clk_sys);
    suspend_clock_gate <= 1'b0;
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 8'h00);
    chk(8'(usb_clk_en_q), 8'h01);
    $display("test suspend done");
    do_reset;
    rd(OFS_ENABLES, 8'h10);
    rd(OFS_ADDR, 8'h80);
    rd(OFS_EPSEL, 8'h00);
    chk(8'(endpoint_index_q), 8'h00);
    chk(8'(usb_irq_q), 8'h00);
    $display("test second reset done");
    end_sim;
  end
endmodule : ugev_top_tb
